// >>> core/tpc_pkg.sv
// Shared constants and types of the turret parallel control port
package tpc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ     = 25_000_000;
    localparam int CLK_KHZ    = CLK_HZ / 1000;
    localparam int QUAL_MS    = 50;
    localparam int DELAY_MS   = 300;
    localparam int MOVE_MS    = 500;
    localparam int SETTLE_MS  = 50;
    localparam int QUAL_CYC   = QUAL_MS * CLK_KHZ;
    localparam int DELAY_CYC  = DELAY_MS * CLK_KHZ;
    localparam int MOVE_CYC   = MOVE_MS * CLK_KHZ;
    localparam int SETTLE_CYC = SETTLE_MS * CLK_KHZ;
    localparam int TMR_W      = 24;

    // ----------------------------------------------------------------
    // Positions, codes and selections
    // ----------------------------------------------------------------
    localparam logic [2:0] POS_FIRST = 3'h1;
    localparam logic [2:0] POS_LAST  = 3'h5;
    localparam logic [2:0] POS_RESET = 3'h1;
    localparam logic [2:0] CODE_NONE = 3'h7;
    localparam int         CH_FWD    = 0;
    localparam int         CH_REV    = 1;
    localparam logic       DIR_FWD   = 1'b0;
    localparam logic       DIR_REV   = 1'b1;
    localparam logic       MODE_FOLLOW = 1'b0;
    localparam logic       MODE_FORCED = 1'b1;
    localparam logic       DELAY_OFF   = 1'b0;
    localparam logic       DELAY_ON    = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_DELAY  = 2'b01,
        ST_MOVE   = 2'b10,
        ST_SETTLE = 2'b11
    } tpc_state_t;

    // Position code as {bit3, bit2, bit1}, low = asserted
    function automatic logic [2:0] tpc_pos_code(input logic [2:0] pos);
        case (pos)
            3'h1:    tpc_pos_code = 3'h6;
            3'h2:    tpc_pos_code = 3'h5;
            3'h3:    tpc_pos_code = 3'h4;
            3'h4:    tpc_pos_code = 3'h3;
            3'h5:    tpc_pos_code = 3'h2;
            default: tpc_pos_code = CODE_NONE;
        endcase
    endfunction

endpackage

// >>> core/tpc_tmr_if.sv
// Interface between the sequencer and its interval timer
`timescale 1ns/1ns
`default_nettype none
interface tpc_tmr_if #(parameter int W = 24);
    logic         load;
    logic [W-1:0] value;
    logic         expired;
    modport ctrl (output load, output value, input expired);
    modport tmr  (input load, input value, output expired);
endinterface
`default_nettype wire

// >>> core/tpc_timer.sv
// Loadable down-counting interval timer
`timescale 1ns/1ns
`default_nettype none
module tpc_timer
    import tpc_pkg::*;
#(
    parameter int W = TMR_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Timer port
    tpc_tmr_if.tmr   tif
);
    if (W < 2) begin : g_chk
        $error("W must be at least 2");
    end

    typedef struct packed {
        logic [W-1:0] cnt;
    } tpc_tmr_st_t;

    tpc_tmr_st_t r;
    tpc_tmr_st_t s;

    always_comb begin
        s = r;
        if (tif.load) begin
            s.cnt = tif.value;
        end else if (r.cnt != '0) begin
            s.cnt = r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r <= '0;
        end else begin
            r <= s;
        end
    end

    assign tif.expired = (r.cnt == '0);

    property p_tmr_load;
        @(posedge clk_i) disable iff (!reset_n_i)
        tif.load && tif.value > 1 |=> !tif.expired;
    endproperty
    a_tmr_load: assert property (p_tmr_load)
        else $error("timer expired right after load");
endmodule
`default_nettype wire

// >>> core/tpc_cmd_filter.sv
// Low-level qualification filter for the rotation command inputs
`timescale 1ns/1ns
`default_nettype none
module tpc_cmd_filter
    import tpc_pkg::*;
#(
    parameter int N        = 2,
    parameter int QUAL_CYC = tpc_pkg::QUAL_CYC
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         reset_n_i,
    // Commands
    input  wire logic [N-1:0] raw_n_i,
    output logic      [N-1:0] qual_o
);
    localparam int CW = $clog2(QUAL_CYC + 1);
    localparam logic [CW-1:0] QMAX = CW'(QUAL_CYC);

    if (QUAL_CYC < 2) begin : g_chk
        $error("QUAL_CYC must be at least 2");
    end

    typedef struct packed {
        logic [N-1:0][CW-1:0] cnt;
        logic [N-1:0]         qual;
    } tpc_flt_st_t;

    tpc_flt_st_t          r;
    tpc_flt_st_t          s;
    logic [N-1:0][CW-1:0] cnt_nxt;

    for (genvar i = 0; i < N; i++) begin : g_ch
        assign cnt_nxt[i] = raw_n_i[i] ? '0 :
            ((r.cnt[i] == QMAX) ? QMAX : r.cnt[i] + 1'b1);

        property p_high_drops;
            @(posedge clk_i) disable iff (!reset_n_i)
            raw_n_i[i] |=> !qual_o[i];
        endproperty
        a_high_drops: assert property (p_high_drops)
            else $error("command kept qualified after release");

        property p_rise_needs_low;
            @(posedge clk_i) disable iff (!reset_n_i)
            $rose(qual_o[i]) |-> $past(!raw_n_i[i], 1)
                && $past(!raw_n_i[i], 2);
        endproperty
        a_rise_needs_low: assert property (p_rise_needs_low)
            else $error("command qualified without a held low");
    end

    always_comb begin
        s = r;
        for (int j = 0; j < N; j++) begin
            s.cnt[j]  = cnt_nxt[j];
            s.qual[j] = (cnt_nxt[j] == QMAX);
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r <= '0;
        end else begin
            r <= s;
        end
    end

    assign qual_o = r.qual;
endmodule
`default_nettype wire

// >>> core/tpc_turret_port.sv
// Parallel control port of a motorized objective turret
`timescale 1ns/1ns
`default_nettype none
module tpc_turret_port
    import tpc_pkg::*;
#(
    parameter int QUAL_CYC   = tpc_pkg::QUAL_CYC,
    parameter int DELAY_CYC  = tpc_pkg::DELAY_CYC,
    parameter int MOVE_CYC   = tpc_pkg::MOVE_CYC,
    parameter int SETTLE_CYC = tpc_pkg::SETTLE_CYC
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // Rotation commands
    input  wire logic forward_cmd_n_i,
    input  wire logic reverse_cmd_n_i,
    // Configuration
    input  wire logic start_delay_select_i,
    input  wire logic rotating_out_mode_select_i,
    // Status
    output logic      position_code_bit1_n_o,
    output logic      position_code_bit2_n_o,
    output logic      position_code_bit3_n_o,
    output logic      in_position_n_o,
    output logic      rotating_flag_o,
    output logic      rotating_flag_n_o,
    // Motor drive
    output logic      motor_fwd_o,
    output logic      motor_rev_o
);
    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    localparam longint TMR_MAX = (64'h1 << TMR_W) - 1;

    if (DELAY_CYC < 1 || DELAY_CYC > TMR_MAX) begin : g_chk_delay
        $error("DELAY_CYC out of timer range");
    end
    if (MOVE_CYC < 2 || MOVE_CYC > TMR_MAX) begin : g_chk_move
        $error("MOVE_CYC out of timer range");
    end
    if (SETTLE_CYC < 2 || SETTLE_CYC > TMR_MAX) begin : g_chk_settle
        $error("SETTLE_CYC out of timer range");
    end

    localparam logic [TMR_W-1:0] T_DELAY  = TMR_W'(DELAY_CYC);
    localparam logic [TMR_W-1:0] T_MOVE   = TMR_W'(MOVE_CYC);
    localparam logic [TMR_W-1:0] T_SETTLE = TMR_W'(SETTLE_CYC);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        tpc_state_t state;
        logic [2:0] pos;
        logic       dir;
        logic [1:0] qprev;
        logic [2:0] code;
        logic       in_pos_n;
        logic       rot;
        logic       rot_n;
        logic       mfwd;
        logic       mrev;
    } tpc_top_st_t;

    tpc_top_st_t r;
    tpc_top_st_t s;

    tpc_tmr_if #(.W(TMR_W)) tif ();

    logic [1:0] q;
    logic [1:0] newq;
    logic       rev_ok;
    logic       go_fwd;
    logic       go_rev;
    logic       again;

    // ----------------------------------------------------------------
    // Command qualification and timer
    // ----------------------------------------------------------------
    tpc_cmd_filter #(
        .N        (2),
        .QUAL_CYC (QUAL_CYC)
    ) u_filter (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .raw_n_i   ({reverse_cmd_n_i, forward_cmd_n_i}),
        .qual_o    (q)
    );

    tpc_timer #(
        .W (TMR_W)
    ) u_timer (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .tif       (tif)
    );

    // ----------------------------------------------------------------
    // Start decisions
    // ----------------------------------------------------------------
    assign newq   = q & ~r.qprev;
    // Reverse from the first position needs forward held as well
    assign rev_ok = (r.pos != POS_FIRST) || q[CH_FWD];
    // Forward alone only while reverse is released
    assign go_fwd = newq[CH_FWD] && reverse_cmd_n_i;
    assign go_rev = newq[CH_REV] && rev_ok;
    assign again  = (r.dir == DIR_FWD) ? q[CH_FWD] && reverse_cmd_n_i
                                       : q[CH_REV] && rev_ok;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        s         = r;
        s.qprev   = q;
        tif.load  = 1'b0;
        tif.value = '0;
        case (r.state)
            ST_IDLE: begin
                if (go_rev || go_fwd) begin
                    s.dir = go_rev ? DIR_REV : DIR_FWD;
                    tif.load = 1'b1;
                    if (start_delay_select_i == DELAY_ON) begin
                        s.state   = ST_DELAY;
                        tif.value = T_DELAY;
                    end else begin
                        s.state   = ST_MOVE;
                        tif.value = T_MOVE;
                    end
                end
            end
            ST_DELAY: begin
                if (tif.expired) begin
                    s.state   = ST_MOVE;
                    tif.load  = 1'b1;
                    tif.value = T_MOVE;
                end
            end
            ST_MOVE: begin
                if (tif.expired) begin
                    if (r.dir == DIR_FWD) begin
                        s.pos = (r.pos == POS_LAST) ? POS_FIRST
                                                    : r.pos + 3'h1;
                    end else begin
                        s.pos = (r.pos == POS_FIRST) ? POS_LAST
                                                     : r.pos - 3'h1;
                    end
                    s.state   = ST_SETTLE;
                    tif.load  = 1'b1;
                    tif.value = T_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (tif.expired) begin
                    if (again) begin
                        s.state   = ST_MOVE;
                        tif.load  = 1'b1;
                        tif.value = T_MOVE;
                    end else begin
                        s.state = ST_IDLE;
                    end
                end
            end
            default: begin
                s.state = ST_IDLE;
            end
        endcase

        // Status outputs; turret still rests at its stop during the delay
        s.in_pos_n = !(s.state == ST_IDLE || s.state == ST_DELAY);
        s.code     = s.in_pos_n ? CODE_NONE : tpc_pos_code(s.pos);
        s.rot      = (s.state == ST_MOVE);
        s.rot_n    = (rotating_out_mode_select_i == MODE_FORCED)
                     ? 1'b1 : !s.rot;
        s.mfwd     = s.rot && (s.dir == DIR_FWD);
        s.mrev     = s.rot && (s.dir == DIR_REV);
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r          <= '0;
            r.state    <= ST_IDLE;
            r.pos      <= POS_RESET;
            r.dir      <= DIR_FWD;
            r.code     <= 3'h6;
            r.in_pos_n <= 1'b0;
            r.rot_n    <= 1'b1;
        end else begin
            r <= s;
        end
    end

    assign position_code_bit1_n_o = r.code[0];
    assign position_code_bit2_n_o = r.code[1];
    assign position_code_bit3_n_o = r.code[2];
    assign in_position_n_o        = r.in_pos_n;
    assign rotating_flag_o        = r.rot;
    assign rotating_flag_n_o      = r.rot_n;
    assign motor_fwd_o            = r.mfwd;
    assign motor_rev_o            = r.mrev;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    property p_code_legal;
        !in_position_n_o |-> r.code inside {3'h6, 3'h5, 3'h4, 3'h3, 3'h2};
    endproperty
    a_code_legal: assert property (p_code_legal)
        else $error("illegal position code at rest");

    property p_stop_after_settle;
        $fell(in_position_n_o) |-> $past(r.state) == ST_SETTLE
            && $past(tif.expired);
    endproperty
    a_stop_after_settle: assert property (p_stop_after_settle)
        else $error("in-position asserted without settling");

    property p_rot_undef;
        rotating_flag_o |-> in_position_n_o && r.code == CODE_NONE
            && (motor_fwd_o ^ motor_rev_o);
    endproperty
    a_rot_undef: assert property (p_rot_undef)
        else $error("rotating with a valid position code");

    property p_rotn_mode;
        rotating_out_mode_select_i == MODE_FORCED |=> rotating_flag_n_o;
    endproperty
    a_rotn_mode: assert property (p_rotn_mode)
        else $error("inverted flag not forced high");

    property p_rotn_follow;
        rotating_out_mode_select_i == MODE_FOLLOW
            |=> rotating_flag_n_o == !rotating_flag_o;
    endproperty
    a_rotn_follow: assert property (p_rotn_follow)
        else $error("inverted flag does not follow");

    property p_delay_start;
        r.state == ST_IDLE && (go_fwd || go_rev)
            && start_delay_select_i == DELAY_ON
            |=> r.state == ST_DELAY && !rotating_flag_o
            ##1 !rotating_flag_o;
    endproperty
    a_delay_start: assert property (p_delay_start)
        else $error("motion started without the delay");

    property p_step_one;
        r.state == ST_MOVE && tif.expired |=> r.pos != $past(r.pos)
            && r.state == ST_SETTLE;
    endproperty
    a_step_one: assert property (p_step_one)
        else $error("step end did not advance position");

    property p_settle;
        $fell(rotating_flag_o) |-> in_position_n_o ##1 in_position_n_o;
    endproperty
    a_settle: assert property (p_settle)
        else $error("no settling after the step");

    property p_successive;
        r.state == ST_SETTLE && tif.expired && again
            |=> rotating_flag_o && r.state == ST_MOVE;
    endproperty
    a_successive: assert property (p_successive)
        else $error("held command did not continue");

    property p_refuse;
        r.state == ST_IDLE && r.pos == POS_FIRST && newq[CH_REV]
            && !q[CH_FWD] |=> r.state == ST_IDLE && r.pos == POS_FIRST;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("plain reverse from position 1 not refused");

    property p_override;
        r.state == ST_IDLE && r.pos == POS_FIRST && newq[CH_REV]
            && q[CH_FWD] |=> r.state != ST_IDLE && r.dir == DIR_REV;
    endproperty
    a_override: assert property (p_override)
        else $error("override reverse from position 1 refused");

    c_fwd_step:   cover property ($rose(motor_fwd_o));
    c_override:   cover property (r.pos == POS_FIRST && $rose(motor_rev_o));
    c_successive: cover property (r.state == ST_SETTLE && tif.expired
                                  && again);
    c_refused:    cover property (r.state == ST_IDLE && r.pos == POS_FIRST
                                  && newq[CH_REV] && !q[CH_FWD]);
endmodule
`default_nettype wire

// >>> sim/tpc_ctl_model.sv
// Model of the external controller that drives the rotation commands
`timescale 1ns/1ns
`default_nettype none
module tpc_ctl_model (
    // Clock
    input  wire logic clk_i,
    // Commands to the turret port
    output var logic  forward_cmd_n_o,
    output var logic  reverse_cmd_n_o
);
    // Idle lines sit at their pull-up level
    initial begin
        forward_cmd_n_o = 1'b1;
        reverse_cmd_n_o = 1'b1;
    end

    // ----------------------------------------------------------------
    // Command press, called at a falling edge, held for hold edges
    // ----------------------------------------------------------------
    task automatic press(input logic fwd, input logic rev, input int hold);
        forward_cmd_n_o = ~fwd;
        reverse_cmd_n_o = ~rev;
        repeat (hold) @(negedge clk_i);
        forward_cmd_n_o = 1'b1;
        reverse_cmd_n_o = 1'b1;
    endtask
endmodule
`default_nettype wire

// >>> sim/tpc_turret_port_bench.sv
// Self-checking bench of the turret parallel control port
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tpc_turret_port_bench;
    import tpc_pkg::*;
    localparam int QC = 4;
    localparam int DC = 8;
    localparam int MC = 10;
    localparam int SC = 4;

    logic        clk_i     = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        dly_sel   = 1'b0;
    logic        mode_sel  = 1'b0;
    wire logic   fwd_n;
    wire logic   rev_n;
    logic        b1, b2, b3, inpos_n, rot, rot_n, mot_f, mot_r;
    logic        rot_p     = 1'b0;
    logic        inpos_p   = 1'b0;
    int          n_fail    = 0;
    int          cmp_count = 0;
    int          cyc       = 0;
    int          rise_c    = 0;
    int          fall_c    = 0;
    int          q_rise[$];
    logic [2:0]  q_code[$];
    logic [2:0]  pos       = 3'h1;
    logic [31:0] seed      = 32'h8065;
    int          exp_rise  = 0;
    logic [2:0]  exp_code  = 3'h0;
    logic        exp_rev   = 1'b0;

    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;

    tpc_ctl_model ctl (
        .clk_i           (clk_i),
        .forward_cmd_n_o (fwd_n),
        .reverse_cmd_n_o (rev_n)
    );

    tpc_turret_port #(
        .QUAL_CYC   (QC),
        .DELAY_CYC  (DC),
        .MOVE_CYC   (MC),
        .SETTLE_CYC (SC)
    ) dut (
        .clk_i                      (clk_i),
        .reset_n_i                  (reset_n_i),
        .forward_cmd_n_i            (fwd_n),
        .reverse_cmd_n_i            (rev_n),
        .start_delay_select_i       (dly_sel),
        .rotating_out_mode_select_i (mode_sel),
        .position_code_bit1_n_o     (b1),
        .position_code_bit2_n_o     (b2),
        .position_code_bit3_n_o     (b3),
        .in_position_n_o            (inpos_n),
        .rotating_flag_o            (rot),
        .rotating_flag_n_o          (rot_n),
        .motor_fwd_o                (mot_f),
        .motor_rev_o                (mot_r)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    // Expected code as {bit1, bit2, bit3}
    function automatic logic [2:0] code_of(input logic [2:0] p);
        case (p)
            3'h1:    return 3'h3;
            3'h2:    return 3'h5;
            3'h3:    return 3'h1;
            3'h4:    return 3'h6;
            default: return 3'h2;
        endcase
    endfunction

    task automatic tally_and_finish;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Note expectations, press, then wait for rest
    task automatic cmd(input logic f, input logic r, input int hold,
                       input logic [2:0] dest, input bit moves,
                       input logic dly);
        int n;
        @(negedge clk_i);
        dly_sel = dly;
        exp_rev = r;
        if (moves) begin
            // Delay state runs DELAY_CYC + 1 cycles before motion
            q_rise.push_back(cyc + QC + 1 + (dly ? DC + 1 : 0));
            q_code.push_back(code_of(dest));
        end
        ctl.press(f, r, hold);
        repeat (30) @(negedge clk_i);
        for (n = 0; n < 300; n++) begin
            if (q_code.size() == 0 && inpos_n === 1'b0) break;
            @(negedge clk_i);
        end
        `CHK(q_code.size(), 0)
        `CHK(q_rise.size(), 0)
        if (moves) pos = dest;
    endtask

    // ----------------------------------------------------------------
    // Output monitor
    // ----------------------------------------------------------------
    always @(negedge clk_i) begin
        if (reset_n_i) begin
            if (rot === 1'b1 && rot_p === 1'b0) begin
                `CHK(rot_n, mode_sel)
                `CHK({b1, b2, b3}, 3'h7)
                `CHK(inpos_n, 1'b1)
                `CHK({mot_f, mot_r}, {~exp_rev, exp_rev})
                if (inpos_p === 1'b0) begin
                    if (q_rise.size() == 0) begin
                        `CHK(1'b1, 1'b0)
                    end else begin
                        exp_rise = q_rise.pop_front();
                        `CHK(cyc, exp_rise)
                    end
                end
                rise_c = cyc;
            end
            if (rot === 1'b0 && rot_p === 1'b1) begin
                `CHK(cyc - rise_c, MC + 1)
                `CHK({mot_f, mot_r}, 2'h0)
                fall_c = cyc;
            end
            if (inpos_n === 1'b0 && inpos_p === 1'b1) begin
                `CHK(cyc - fall_c, SC + 1)
                `CHK(rot, 1'b0)
                if (q_code.size() == 0) begin
                    `CHK(1'b1, 1'b0)
                end else begin
                    exp_code = q_code.pop_front();
                    `CHK({b1, b2, b3}, exp_code)
                end
            end
            rot_p   = rot;
            inpos_p = inpos_n;
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int i;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        reset_n_i = 1'b1;
        `CHK({b1, b2, b3}, 3'h3)
        `CHK(inpos_n, 1'b0)
        `CHK(rot, 1'b0)
        `CHK(rot_n, 1'b1)
        cmd(1'b1, 1'b0, QC - 1, pos, 1'b0, 1'b0);
        cmd(1'b0, 1'b1, QC + 4, pos, 1'b0, 1'b1);
        `CHK({b1, b2, b3}, 3'h3)
        for (i = 0; i < 5; i++) begin
            seed = xs(seed);
            mode_sel = seed[0];
            cmd(1'b1, 1'b0, QC + int'(seed[3:2]), (pos % 5) + 3'h1,
                1'b1, seed[1]);
        end
        mode_sel = 1'b1;
        cmd(1'b1, 1'b1, QC + 2, 3'h5, 1'b1, 1'b0);
        mode_sel = 1'b0;
        cmd(1'b0, 1'b1, QC + 1, 3'h4, 1'b1, 1'b0);
        cmd(1'b1, 1'b0, 28, 3'h1, 1'b1, 1'b0);
        `CHK({b1, b2, b3}, 3'h3)
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
